// ### pkg/sas_pkg.sv
// Package with register map, field positions, reset values and timing for the converter sequencer.
package sas_pkg;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_OPT = 12'h004;
    localparam logic [11:0] OFF_RES1 = 12'h008;
    localparam logic [11:0] OFF_STAT = 12'h018;
    localparam int CTRL_DONE_BIT = 7;
    localparam int CTRL_SCAN_BIT = 5;
    localparam int CTRL_GROUP_MODE_SEL_BIT = 4;
    localparam int OPT_PWR_BIT = 7;
    localparam int OPT_CONV_CLOCK_SOURCE_SEL_BIT = 6;
    localparam int OPT_DLY_BIT = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] OPT_RESET = 8'h10;
    localparam logic [7:0] OPT_WMASK = 8'hfb;
    localparam logic [7:0] CTRL_WMASK = 8'h3f;
    localparam int CLK_MHZ = 100;
    localparam int PROT_CYCLES = 64;
    localparam int STOP_DELAY_CYCLES = 4000;
    localparam int STOP_FAST_CYCLES = 4;
    localparam int SAMPLE_CYCLES = 12;
    localparam int CMP_WAIT_CYCLES = 5;
    localparam int SAR_BITS = 8;
    localparam int SEQ_LEN = 4;
    localparam int SETTLE_US = 100;
    localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
    localparam int STOP_SETTLE_MS = 10;
    localparam logic [7:0] FULL_SCALE = 8'hff;
    localparam logic [7:0] ZERO_SCALE = 8'h00;
    typedef enum logic [2:0] {
        SAS_IDLE = 3'b000,
        SAS_SAMPLE = 3'b001,
        SAS_CONVERT = 3'b010,
        SAS_STORE = 3'b011,
        SAS_SUSPEND = 3'b100,
        SAS_WAKE = 3'b101
    } sas_state_t;
endpackage

// ### pkg/sas_res_if.sv
// Interface carrying one conversion result from the sequencer into the result store.
`timescale 1ns/1ns
`default_nettype none
interface sas_res_if;
    logic wr;
    logic [1:0] slot;
    logic [7:0] data;
    logic [31:0] rd_word;
    logic [1:0] rd_slot;
    modport seq (output wr, output slot, output data, output rd_slot, input rd_word);
    modport store (input wr, input slot, input data, input rd_slot, output rd_word);
endinterface
`default_nettype wire

// ### src/sas_result_store.sv
// Four read-only result slots written only by the conversion sequencer.
`timescale 1ns/1ns
`default_nettype none
module sas_result_store (
    input wire logic pclk,
    input wire logic presetn,
    sas_res_if.store res
);
    logic [7:0] slot_q [4];
    logic [7:0] slot_d [4];

    // Each slot takes the finished approximation when the store strobe addresses its index.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_slot
            always_comb begin
                slot_d[g] = slot_q[g];
                if (res.wr && res.slot == 2'(g)) begin
                    slot_d[g] = res.data; // R2
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    slot_q[g] <= 8'h00;
                end else begin
                    slot_q[g] <= slot_d[g];
                end
            end
        end
    endgenerate

    // Read port; the bus has no write path here, so writes cannot alter results.
    assign res.rd_word = {24'h000000, slot_q[res.rd_slot]}; // R24

    // The store strobe is the only way a slot may change.
    chk_slot_load: assert property (@(posedge pclk) disable iff (!presetn) // R2
        res.wr && res.slot == 2'h0 |=> slot_q[0] == $past(res.data))
        else $error("Result slot one missed its store.");
    chk_slot_hold: assert property (@(posedge pclk) disable iff (!presetn) // R24
        !res.wr |=> $stable(slot_q[0]) && $stable(slot_q[3]))
        else $error("Result slot changed without a store.");
endmodule
`default_nettype wire

// ### src/sas_top.sv
// APB-controlled sequencer for an 8-bit successive-approximation converter.
//
// Contract
// R1 - Each conversion is eight comparisons, MSB first, each fixing one bit.
// R2 - Finished approximation is copied into the slot's result register.
// R3 - Option bit 7 powers the converter up when set, down when clear.
// R4 - Software waits up to 100 us after power-up before converting.
// R5 - Clock-select bit picks bus clock at 0, RC clock at 1.
// R6 - Software should pick RC clock below 750 kHz bus clock.
// R7 - A sequence starts one cycle after a control write made while powered up.
// R8 - Sequences hold four conversions; done flag sets after the fourth.
// R9 - Low reference gives 00, high reference gives ff, no overflow.
// R10 - Control bits 3:0 pick one of 16 inputs.
// R11 - Group mode stores each channel by its position in the group.
// R12 - Single one-shot: convert four times, fill slots, then halt.
// R13 - Single continuous: keep converting, wrapping slots one to four.
// R14 - Group one-shot: convert each group channel once, then halt.
// R15 - Group continuous: cycle the group, overwriting older results.
// R16 - Stop or wait suspends the channel; resume resamples it.
// R17 - After a fast stop exit software waits 10 ms.
// R18 - Delay bit set gives 4000 cycles stop exit, else four.
// R19 - Control write mid-sequence aborts and restarts with new settings.
// R20 - Done flag clears on control write, sets when four slots valid; a control write while powered down leaves it unchanged.
// R21 - Control bit 6 reads zero, others except done are read/write.
// R22 - Protected option bits take one write in first 64 cycles.
// R23 - Group mode ignores two low select bits, upper two pick group.
// R24 - Result registers are read-only; writes change nothing.
// R25 - Control writes while powered down start nothing.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module sas_top #(
    parameter int STOP_DELAY = sas_pkg::STOP_DELAY_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic special_mode,
    input wire logic stop_req,
    input wire logic wait_req,
    input wire logic comp_in,
    output logic [3:0] mux_sel,
    output logic [7:0] dac_code,
    output logic sample_en,
    output logic converter_power_on,
    output logic conv_clock_source_sel
);
    ////////////////////////////////////////////////////////////////////////
    // Bus decode.
    logic wr_en;
    logic rd_en;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite; // Setup phase, so data stands with pready.

    sas_res_if res ();
    sas_result_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .res(res)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for comparator and low-power requests.
    logic [2:0] cmp_s_q;
    logic [2:0] stp_s_q;
    logic [2:0] wt_s_q;
    logic cmp_v_q;
    logic hold_v_q;
    logic [2:0] cmp_s_d;
    logic [2:0] stp_s_d;
    logic [2:0] wt_s_d;
    logic cmp_v_d;
    logic hold_v_d;
    logic stp_v_q;
    logic stp_v_d;

    // Stage 1 feeds stage 2 only; a change counts when stages 2 and 3 agree.
    always_comb begin
        cmp_s_d = {cmp_s_q[1:0], comp_in};
        stp_s_d = {stp_s_q[1:0], stop_req};
        wt_s_d = {wt_s_q[1:0], wait_req};
        cmp_v_d = (cmp_s_q[1] == cmp_s_q[2]) ? cmp_s_q[2] : cmp_v_q;
        stp_v_d = (stp_s_q[1] == stp_s_q[2]) ? stp_s_q[2] : stp_v_q;
        hold_v_d = (wt_s_q[1] == wt_s_q[2]) ? wt_s_q[2] : hold_v_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_s_q <= 3'h0;
            stp_s_q <= 3'h0;
            wt_s_q <= 3'h0;
            cmp_v_q <= 1'b0;
            stp_v_q <= 1'b0;
            hold_v_q <= 1'b0;
        end else begin
            cmp_s_q <= cmp_s_d;
            stp_s_q <= stp_s_d;
            wt_s_q <= wt_s_d;
            cmp_v_q <= cmp_v_d;
            stp_v_q <= stp_v_d;
            hold_v_q <= hold_v_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Option register with write-once protection window.
    logic [7:0] opt_q;
    logic [7:0] opt_d;
    logic [6:0] prot_cnt_q;
    logic [6:0] prot_cnt_d;
    logic opt_used_q;
    logic opt_used_d;
    logic opt_wr;
    logic opt_ok;
    assign opt_wr = wr_en && paddr == sas_pkg::OFF_OPT;
    assign opt_ok = special_mode || (!opt_used_q && prot_cnt_q < 7'(sas_pkg::PROT_CYCLES));

    // Protected bits take one write early after reset, or any time in special mode.
    always_comb begin
        opt_d = opt_q;
        opt_used_d = opt_used_q;
        prot_cnt_d = prot_cnt_q;
        if (prot_cnt_q < 7'(sas_pkg::PROT_CYCLES)) begin
            prot_cnt_d = prot_cnt_q + 7'h01;
        end
        if (opt_wr && opt_ok) begin
            opt_d = pwdata[7:0] & sas_pkg::OPT_WMASK; // R22
            opt_used_d = 1'b1; // R22
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_q <= sas_pkg::OPT_RESET;
            opt_used_q <= 1'b0;
            prot_cnt_q <= 7'h00;
        end else begin
            opt_q <= opt_d;
            opt_used_q <= opt_used_d;
            prot_cnt_q <= prot_cnt_d;
        end
    end

    logic pwr_on;
    assign pwr_on = opt_q[sas_pkg::OPT_PWR_BIT]; // R3

    ////////////////////////////////////////////////////////////////////////
    // Control register, sequencer and approximation register.
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic done_q;
    logic done_d;
    logic start_q;
    logic start_d;
    sas_pkg::sas_state_t st_q;
    sas_pkg::sas_state_t st_d;
    logic [7:0] sar_q;
    logic [7:0] sar_d;
    logic [2:0] bit_q;
    logic [2:0] bit_d;
    logic [1:0] slot_q;
    logic [1:0] slot_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [11:0] wake_q;
    logic [11:0] wake_d;
    logic ctrl_wr;
    logic lowp;
    logic [3:0] chan;
    logic [1:0] pos;
    assign ctrl_wr = wr_en && paddr == sas_pkg::OFF_CTRL;
    assign lowp = stp_v_q || hold_v_q;
    // Group mode replaces the low select bits with the slot position; next values keep
    // the pin in step with the sample strobe.
    assign chan = ctrl_d[sas_pkg::CTRL_GROUP_MODE_SEL_BIT] ? {ctrl_d[3:2], slot_d} : ctrl_d[3:0]; // R10 R23
    assign pos = slot_q;

    // Sequence control: sample, eight comparisons, store, advance slot.
    always_comb begin
        ctrl_d = ctrl_q;
        done_d = done_q;
        start_d = 1'b0;
        st_d = st_q;
        sar_d = sar_q;
        bit_d = bit_q;
        slot_d = slot_q;
        cnt_d = cnt_q;
        wake_d = wake_q;
        res.wr = 1'b0;
        res.slot = pos; // R11
        res.data = sar_q;
        if (ctrl_wr && pwr_on) begin
            ctrl_d = pwdata[7:0] & sas_pkg::CTRL_WMASK; // R21
            done_d = 1'b0; // R20
            start_d = 1'b1; // R7
        end
        if (start_q) begin
            st_d = sas_pkg::SAS_SAMPLE; // R19
            slot_d = 2'h0;
            cnt_d = 4'h0;
        end else begin
            case (st_q)
                sas_pkg::SAS_IDLE: begin
                    st_d = sas_pkg::SAS_IDLE;
                end
                sas_pkg::SAS_SAMPLE: begin
                    if (lowp) begin
                        st_d = sas_pkg::SAS_SUSPEND; // R16
                    end else if (cnt_q == 4'(sas_pkg::SAMPLE_CYCLES - 1)) begin
                        st_d = sas_pkg::SAS_CONVERT;
                        sar_d = 8'h80; // R1
                        bit_d = 3'h7;
                        cnt_d = 4'h0;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
                sas_pkg::SAS_CONVERT: begin
                    if (lowp) begin
                        st_d = sas_pkg::SAS_SUSPEND; // R16
                    end else if (cnt_q != 4'(sas_pkg::CMP_WAIT_CYCLES - 1)) begin
                        cnt_d = cnt_q + 4'h1; // Let the trial pass the comparator synchroniser.
                    end else begin
                        // Keep the trial bit if input reaches the DAC, then try the next.
                        cnt_d = 4'h0;
                        sar_d[bit_q] = cmp_v_q; // R1 R9
                        if (bit_q == 3'h0) begin
                            st_d = sas_pkg::SAS_STORE;
                        end else begin
                            sar_d[bit_q - 3'h1] = 1'b1;
                            bit_d = bit_q - 3'h1;
                        end
                    end
                end
                sas_pkg::SAS_STORE: begin
                    res.wr = 1'b1; // R2
                    slot_d = slot_q + 2'h1; // R13 R15
                    cnt_d = 4'h0;
                    if (slot_q == 2'(sas_pkg::SEQ_LEN - 1)) begin
                        done_d = 1'b1; // R8 R20
                        st_d = ctrl_q[sas_pkg::CTRL_SCAN_BIT] ? sas_pkg::SAS_SAMPLE
                                                              : sas_pkg::SAS_IDLE; // R12 R14
                    end else begin
                        st_d = sas_pkg::SAS_SAMPLE;
                    end
                end
                sas_pkg::SAS_SUSPEND: begin
                    if (stp_v_q) begin
                        wake_d = opt_q[sas_pkg::OPT_DLY_BIT] ? 12'(STOP_DELAY - 1)
                                                             : 12'(sas_pkg::STOP_FAST_CYCLES - 1);
                    end else if (!hold_v_q) begin
                        st_d = sas_pkg::SAS_WAKE; // R18
                    end
                end
                sas_pkg::SAS_WAKE: begin
                    if (lowp) begin
                        st_d = sas_pkg::SAS_SUSPEND;
                    end else if (wake_q == 12'h000) begin
                        st_d = sas_pkg::SAS_SAMPLE; // R16
                        cnt_d = 4'h0;
                    end else begin
                        wake_d = wake_q - 12'h001; // R18
                    end
                end
                default: begin
                    st_d = sas_pkg::SAS_IDLE;
                end
            endcase
        end
        if (!pwr_on) begin
            st_d = sas_pkg::SAS_IDLE; // R3 R25
        end
        if (ctrl_wr && pwr_on) begin
            done_d = 1'b0; // R20
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= sas_pkg::CTRL_RESET;
            done_q <= 1'b0;
            start_q <= 1'b0;
            st_q <= sas_pkg::SAS_IDLE;
            sar_q <= 8'h00;
            bit_q <= 3'h0;
            slot_q <= 2'h0;
            cnt_q <= 4'h0;
            wake_q <= 12'h000;
        end else begin
            ctrl_q <= ctrl_d;
            done_q <= done_d;
            start_q <= start_d;
            st_q <= st_d;
            sar_q <= sar_d;
            bit_q <= bit_d;
            slot_q <= slot_d;
            cnt_q <= cnt_d;
            wake_q <= wake_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux and registered outputs.
    logic [31:0] rd_d;
    logic [11:0] res_off;
    assign res_off = paddr - sas_pkg::OFF_RES1;
    assign res.rd_slot = res_off[3:2];

    // Reads return registers; done flag at bit 7, bit 6 forced low.
    always_comb begin
        rd_d = 32'h00000000;
        if (paddr == sas_pkg::OFF_CTRL) begin
            rd_d = {24'h000000, done_q, 1'b0, ctrl_q[5:0]}; // R21
        end else if (paddr == sas_pkg::OFF_OPT) begin
            rd_d = {24'h000000, opt_q};
        end else if (paddr >= sas_pkg::OFF_RES1 && paddr < sas_pkg::OFF_STAT) begin
            rd_d = res.rd_word;
        end else if (paddr == sas_pkg::OFF_STAT) begin
            rd_d = {29'h00000000, st_q};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            mux_sel <= 4'h0;
            dac_code <= 8'h00;
            sample_en <= 1'b0;
            converter_power_on <= 1'b0;
            conv_clock_source_sel <= 1'b0;
        end else begin
            prdata <= rd_en ? rd_d : 32'h00000000;
            pready <= psel && !penable;
            pslverr <= 1'b0;
            mux_sel <= chan;
            dac_code <= sar_d;
            sample_en <= st_d == sas_pkg::SAS_SAMPLE;
            converter_power_on <= pwr_on; // R3
            conv_clock_source_sel <= opt_q[sas_pkg::OPT_CONV_CLOCK_SOURCE_SEL_BIT]; // R5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks and cover points, all sampled on the bus clock outside reset.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_seq_start: assert property (ctrl_wr && pwr_on |=> ##1 sample_en) // R7
        else $error("Sequence did not start one cycle after the write.");
    chk_flag_clear: assert property (ctrl_wr && pwr_on |=> !done_q) // R20
        else $error("Done flag survived a control write.");
    chk_flag_set: assert property ( // R8 R20
        st_q == sas_pkg::SAS_STORE && slot_q == 2'h3 && !start_q && !ctrl_wr |=> done_q)
        else $error("Done flag not set after the fourth result.");
    chk_off_idle: assert property (!pwr_on |=> st_q == sas_pkg::SAS_IDLE) // R3 R25
        else $error("Sequencer ran while powered down.");
    chk_opt_locked: assert property (opt_wr && !opt_ok |=> $stable(opt_q)) // R22
        else $error("Protected option bits took a refused write.");
    chk_bit6_zero: assert property (rd_en && paddr == sas_pkg::OFF_CTRL |=> !prdata[6]) // R21
        else $error("Control bit 6 read back as one.");
    cov_seq_end: cover property (st_q == sas_pkg::SAS_STORE && slot_q == 2'h3);
    cov_suspend: cover property (st_q == sas_pkg::SAS_SUSPEND);
    cov_abort: cover property (ctrl_wr && st_q != sas_pkg::SAS_IDLE);
endmodule
`default_nettype wire

// ### bench/sar_adc_sequencer_tb.sv
// Self-checking testbench for the APB converter sequencer with a behavioural result model.
`timescale 1ns/1ns
`default_nettype none
module sar_adc_sequencer_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
    logic special_mode, stop_req, wait_req, comp_in, sample_en;
    logic converter_power_on, conv_clock_source_sel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] mux_sel;
    logic [7:0] dac_code;
    logic [7:0] ana [16];
    logic [7:0] ctl;
    int fails, comparisons, seed;
    localparam int STOP_DELAY = 20;
    ////////////////////////////////////////////////////////////////////////////////
    // The analog inputs are a table; the comparator says whether the input reaches the code.
    assign comp_in = (ana[mux_sel] >= dac_code);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    sas_top #(.STOP_DELAY(STOP_DELAY)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .special_mode(special_mode), .stop_req(stop_req),
        .wait_req(wait_req), .comp_in(comp_in), .mux_sel(mux_sel), .dac_code(dac_code),
        .sample_en(sample_en), .converter_power_on(converter_power_on),
        .conv_clock_source_sel(conv_clock_source_sel));
    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("Counts: comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Compares one value and reports a mismatch at once.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer: setup, then access until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        logic ok;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        ok = 1'b0;
        // Answer values are taken on the falling edge, where they already stand
        // unchanged up to the rising edge that completes the transfer.
        while (!ok && n < 50) begin
            @(negedge pclk);
            ok = (pready === 1'b1);
            rd = prdata;
            slverr = pslverr;
            @(posedge pclk);
            n++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!ok) begin
            fails++;
            $display("BAD pready expected 1 seen 0");
            test_done();
        end
    endtask
    // Model of the result a slot must hold for a given control value.
    function automatic logic [7:0] model(input logic [7:0] c, input int i);
        return c[4] ? ana[{c[3:2], i[1:0]}] : ana[c[3:0]];
    endfunction
    // Reads all four slots and compares them with the model.
    task automatic check_slots(input logic [7:0] c);
        logic [7:0] q [$];
        for (int i = 0; i < 4; i++) q.push_back(model(c, i));
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, sas_pkg::OFF_RES1 + 12'(4 * i), 32'h0);
            check("result slot", {24'h0, rd[7:0]}, {24'h0, q.pop_front()});
        end
    endtask
    // Polls the done flag under a bound.
    task automatic wait_done;
        for (int k = 0; k < 300; k++) begin
            apb(1'b0, sas_pkg::OFF_CTRL, 32'h0);
            if (rd[7] === 1'b1) return;
        end
        fails++;
        $display("BAD done flag never set");
        test_done();
    endtask
    // Starts a sequence, checks its start, the cleared flag and the four results.
    task automatic run_seq(input logic [7:0] c);
        apb(1'b1, sas_pkg::OFF_CTRL, {24'h0, c});
        // The write lands at the edge that ends it; sampling shows one edge later.
        repeat (2) @(negedge pclk);
        check("sequence start", {31'h0, sample_en}, 32'h1);
        check("first channel", {28'h0, mux_sel}, {28'h0, c[4] ? {c[3:2], 2'b00} : c[3:0]});
        apb(1'b0, sas_pkg::OFF_CTRL, 32'h0);
        check("control readback", rd, {24'h0, c & sas_pkg::CTRL_WMASK});
        wait_done();
        check_slots(c);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        int bad;
        {psel, penable, pwrite, special_mode, stop_req, wait_req} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        fails = 0;
        comparisons = 0;
        seed = 32'heaa9;
        for (int i = 0; i < 16; i++) ana[i] = 8'($random(seed));
        ana[0] = sas_pkg::ZERO_SCALE;
        ana[1] = sas_pkg::FULL_SCALE;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, sas_pkg::OFF_CTRL, 32'h0);
        check("control reset", rd, {24'h0, sas_pkg::CTRL_RESET});
        apb(1'b0, sas_pkg::OFF_OPT, 32'h0);
        check("option reset", rd, {24'h0, sas_pkg::OPT_RESET});
        apb(1'b1, sas_pkg::OFF_OPT, 32'h0000_00d4);
        apb(1'b1, sas_pkg::OFF_OPT, 32'h0);
        apb(1'b0, sas_pkg::OFF_OPT, 32'h0);
        check("option single write", rd, 32'h0000_00d0);
        check("power pin", {31'h0, converter_power_on}, 32'h1);
        check("clock select pin", {31'h0, conv_clock_source_sel}, 32'h1);
        repeat (sas_pkg::SETTLE_CYCLES) @(posedge pclk);
        // Every mode, first with the reference extremes, then random channels.
        for (int i = 0; i < 8; i++) begin
            ctl = {2'b00, 2'(i % 4), i == 0 ? 4'h1 : (i == 1 ? 4'h0 : 4'($random(seed)))};
            run_seq(ctl);
            bad = 0;
            if (ctl[5] == 1'b0) begin
                for (int k = 0; k < 60; k++) begin
                    @(posedge pclk);
                    if (sample_en !== 1'b0) bad++;
                end
                check("halt after one pass", bad, 0);
            end else begin
                for (int j = 0; j < 16; j++) ana[j] = 8'($random(seed));
                repeat (600) @(posedge pclk);
                check_slots(ctl);
            end
        end
        // Abort of a running sequence by a new write with fresh settings.
        apb(1'b1, sas_pkg::OFF_CTRL, 32'h0000_0025);
        repeat (30) @(posedge pclk);
        run_seq(8'hd7);
        apb(1'b1, sas_pkg::OFF_RES1, {24'h0, ~model(8'hd7, 0)});
        apb(1'b0, sas_pkg::OFF_RES1, 32'h0);
        check("slot write ignored", rd, {24'h0, model(8'hd7, 0)});
        apb(1'b0, 12'h100, 32'h0);
        check("unmapped error", {31'h0, slverr}, 32'h0);
        // Stop, then wait, in mid-sequence; the sequence resumes and completes.
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, sas_pkg::OFF_CTRL, 32'h0000_0012);
            repeat (40) @(posedge pclk);
            stop_req <= (s == 0);
            wait_req <= (s == 1);
            repeat (30) @(posedge pclk);
            check("suspended sampling", {31'h0, sample_en}, 32'h0);
            stop_req <= 1'b0;
            wait_req <= 1'b0;
            repeat (STOP_DELAY + 8) @(posedge pclk);
            wait_done();
            check_slots(8'h12);
        end
        // Power down in special mode; control writes then start nothing.
        special_mode <= 1'b1;
        apb(1'b1, sas_pkg::OFF_OPT, 32'h0);
        repeat (2) @(negedge pclk);
        check("power pin off", {31'h0, converter_power_on}, 32'h0);
        apb(1'b1, sas_pkg::OFF_CTRL, 32'h0000_0003);
        repeat (150) @(posedge pclk);
        apb(1'b0, sas_pkg::OFF_CTRL, 32'h0);
        check("write while off", rd, 32'h0000_0092);
        check_slots(8'h12);
        apb(1'b1, sas_pkg::OFF_OPT, 32'h0000_0080);
        repeat (2) @(negedge pclk);
        check("clock select bus", {31'h0, conv_clock_source_sel}, 32'h0);
        repeat (sas_pkg::SETTLE_CYCLES) @(posedge pclk);
        run_seq(8'h23);
        test_done();
    end
endmodule
`default_nettype wire
